// ### rtl/pcm_codec_pkg.sv
package pcm_codec_pkg;
   localparam int LIN_W = 13;
   localparam int CODE_W = 8;
   localparam int CHORD_W = 3;
   localparam int STEP_W = 4;
   localparam int SIGN_POS = 7;
   localparam int CHORD_LSB = 4;
   localparam int STEP_LSB = 0;
   localparam int FIFO_DEPTH = 16;
   localparam int PWRUP_FRAMES = 2;
   localparam int MAG_W = 12;
   localparam logic [7:0] MU_INVERT = 8'hff;
   localparam logic [7:0] A_INVERT = 8'h55;
   localparam logic [12:0] MU_BIAS = 13'h0021;
   localparam logic [12:0] MU_CLIP = 13'h0fdf;
   localparam logic [2:0] CHORD_TOP = 3'h7;
   localparam logic [2:0] BIT_LAST = 3'h0;
   localparam logic [2:0] BIT_FIRST = 3'h7;
   localparam logic [1:0] FRAME_ZERO = 2'h0;

   typedef struct packed {
      logic sign;
      logic [2:0] chord;
      logic [3:0] step;
   } pcm_code_t;

   typedef struct packed {
      logic valid;
      logic [12:0] sample;
   } lin_word_t;

   typedef enum logic [2:0] {
      ST_DOWN = 3'b001,
      ST_WAKE = 3'b010,
      ST_RUN = 3'b100
   } pwr_state_t;
endpackage

// ### rtl/pcm_codec_top.sv
// Contract
// RULE_01: encode 13-bit linear samples to 8-bit codes, decode 8-bit codes back.
// RULE_02: code fields are sign, three-bit chord, four-bit step.
// RULE_03: all sixteen steps of one chord share the same increment.
// RULE_04: steps carry into chord; each higher chord doubles step increment. In A-law the code gives chord 1 the same increment as chord 0.
// RULE_05: seven chords above the lowest, 6 dB each, about 42 dB.
// RULE_06: law select high gives mu-255 law, low gives A-law, both directions.
// RULE_07: one sample compressed and one expanded per 8 kHz frame.
// RULE_08: power-down input low is low power, high is normal operation.
// RULE_09: powered down gates internal activity and floats transmit data output.
// RULE_10: after power-up, transmit output stays floating at least two tx frames.
// RULE_11: partner supplies the 8 kHz transmit frame sync.
// RULE_12: transmit data output drives only while shifting a sample out.
// RULE_13: sign bit is msb, then chord, then step at lsb end.
`timescale 1ns/1ps
`default_nettype none

module pcm_sample_fifo #(
   parameter int WIDTH = 13,
   parameter int DEPTH = 16
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic flush,
   // fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
   logic [AW:0] count, next_count;
   logic push, pop;

   always_comb
   begin
      push = in_valid && in_ready;
      pop = out_valid && out_ready;
      in_ready = (count != (AW+1)'(DEPTH)) && !flush;
      out_valid = (count != '0) && !flush;
      out_data = mem[rd_ptr];
      next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
      next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
      next_count = count + (AW+1)'(push) - (AW+1)'(pop);
      if (flush)
      begin
         next_wr_ptr = '0;
         next_rd_ptr = '0;
         next_count = '0;
      end
   end

   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end
      else
      begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         count <= next_count;
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (push)
         mem[wr_ptr] <= in_data;
   end
endmodule

module pcm_companding_codec_ctrl #(
   parameter int FIFO_DEPTH = pcm_codec_pkg::FIFO_DEPTH,
   parameter int PWRUP_FRAMES = pcm_codec_pkg::PWRUP_FRAMES
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic arst_n,
   // control pins
   input wire logic companding_law_select,
   input wire logic power_down_in_n,
   // frame and bit timing from the highway
   input wire logic tx_frame_sync,
   input wire logic rx_frame_sync,
   input wire logic tx_bit_tick,
   input wire logic rx_bit_tick,
   // linear sample in, from the converter side
   input wire logic lin_in_valid,
   output logic lin_in_ready,
   input wire logic [pcm_codec_pkg::LIN_W-1:0] lin_in,
   // serial pcm
   output logic pcm_tx_data_out,
   output logic pcm_tx_data_oe,
   input wire logic pcm_rx_data_in,
   // expanded sample out
   output var pcm_codec_pkg::lin_word_t lin_out,
   output logic powered_up
);
   // encode: sign-magnitude, chord from leading one, step from next four bits
   function automatic logic [7:0] compress(input logic [12:0] s, input logic mu);
      logic [12:0] mag;
      logic [2:0] chord;
      logic [3:0] step;
      pcm_codec_pkg::pcm_code_t c;
      mag = s[12] ? 13'(~s + 1'b1) : s;
      chord = '0;
      if (mu)
      begin
         if (mag > pcm_codec_pkg::MU_CLIP)
            mag = pcm_codec_pkg::MU_CLIP;
         mag = mag + pcm_codec_pkg::MU_BIAS;
         for (int i = 0; i < 8; i++)
            if (mag[i+5])
               chord = 3'(i);
         step = mag[chord+1 +: 4];
      end
      else
      begin
         // full-scale negative has no positive twin; pull it into the top chord
         if (mag[pcm_codec_pkg::LIN_W-1])
            mag = mag - 1'b1;
         for (int i = 1; i < 8; i++)
            if (mag[i+4]) // RULE_04 RULE_05
               chord = 3'(i);
         step = (chord == '0) ? mag[4:1] : mag[chord +: 4]; // RULE_02 RULE_03
      end
      c.sign = ~s[12];
      c.chord = chord;
      c.step = step;
      return mu ? (c ^ pcm_codec_pkg::MU_INVERT) : (c ^ pcm_codec_pkg::A_INVERT); // RULE_13
   endfunction

   // decode: step counts linearly, increment doubles per chord (A-law chords 0 and 1 share one increment)
   function automatic logic [12:0] expand(input logic [7:0] code, input logic mu);
      pcm_codec_pkg::pcm_code_t c;
      logic [12:0] mag;
      c = mu ? (code ^ pcm_codec_pkg::MU_INVERT) : (code ^ pcm_codec_pkg::A_INVERT);
      if (mu)
         mag = 13'((({9'h0, c.step} << 1) + 13'h0021) << c.chord) - pcm_codec_pkg::MU_BIAS;
      else if (c.chord == '0)
         mag = 13'({c.step, 1'b1});
      else
         mag = 13'(({9'h1, c.step} << 1 | 13'h1) << (c.chord - 1'b1));
      return c.sign ? mag : 13'(~mag + 1'b1);
   endfunction

   pcm_codec_pkg::pwr_state_t pstate, next_pstate;
   logic [1:0] frames, next_frames;
   logic fst_q, fsr_q, next_fst_q, next_fsr_q;
   logic tx_busy, next_tx_busy, rx_busy, next_rx_busy;
   logic [2:0] tx_bit, next_tx_bit, rx_bit, next_rx_bit;
   logic [7:0] tx_sh, next_tx_sh, rx_sh, next_rx_sh;
   pcm_codec_pkg::lin_word_t next_lin_out;
   logic fifo_valid, fifo_ready, run, fst_rise, fsr_rise;
   logic [12:0] fifo_data;

   assign run = pstate == pcm_codec_pkg::ST_RUN;
   assign powered_up = run;
   assign fst_rise = tx_frame_sync && !fst_q; // RULE_11
   assign fsr_rise = rx_frame_sync && !fsr_q;

   pcm_sample_fifo #(
      .WIDTH(pcm_codec_pkg::LIN_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .core_clk(core_clk),
      .arst_n(arst_n),
      .flush(!run),
      .in_valid(lin_in_valid),
      .in_ready(lin_in_ready),
      .in_data(lin_in),
      .out_valid(fifo_valid),
      .out_ready(fifo_ready),
      .out_data(fifo_data)
   );

   // one sample taken per transmit frame
   assign fifo_ready = run && fst_rise && !tx_busy; // RULE_07

   always_comb
   begin
      next_pstate = pstate;
      next_frames = frames;
      next_fst_q = tx_frame_sync;
      next_fsr_q = rx_frame_sync;
      unique case (pstate)
         pcm_codec_pkg::ST_DOWN:
            if (power_down_in_n) // RULE_08
            begin
               next_pstate = pcm_codec_pkg::ST_WAKE;
               next_frames = pcm_codec_pkg::FRAME_ZERO;
            end
         pcm_codec_pkg::ST_WAKE:
            if (fst_rise)
            begin
               next_frames = frames + 1'b1;
               if (frames == 2'(PWRUP_FRAMES - 1)) // RULE_10
                  next_pstate = pcm_codec_pkg::ST_RUN;
            end
         pcm_codec_pkg::ST_RUN: ;
         default: next_pstate = pcm_codec_pkg::ST_DOWN;
      endcase
      if (!power_down_in_n)
         next_pstate = pcm_codec_pkg::ST_DOWN; // RULE_09
   end

   always_comb
   begin
      next_tx_busy = tx_busy;
      next_tx_bit = tx_bit;
      next_tx_sh = tx_sh;
      next_rx_busy = rx_busy;
      next_rx_bit = rx_bit;
      next_rx_sh = rx_sh;
      next_lin_out = '{valid: 1'b0, sample: lin_out.sample};
      if (!run)
      begin
         next_tx_busy = 1'b0;
         next_rx_busy = 1'b0;
      end
      else
      begin
         if (fifo_ready && fifo_valid)
         begin
            next_tx_sh = compress(fifo_data, companding_law_select); // RULE_01 RULE_06
            next_tx_busy = 1'b1;
            next_tx_bit = pcm_codec_pkg::BIT_FIRST;
         end
         else if (tx_busy && tx_bit_tick)
         begin
            next_tx_sh = {tx_sh[6:0], 1'b0};
            next_tx_bit = tx_bit - 1'b1;
            if (tx_bit == pcm_codec_pkg::BIT_LAST)
               next_tx_busy = 1'b0;
         end
         if (fsr_rise && !rx_busy)
         begin
            next_rx_busy = 1'b1;
            next_rx_bit = pcm_codec_pkg::BIT_FIRST;
         end
         else if (rx_busy && rx_bit_tick)
         begin
            next_rx_sh = {rx_sh[6:0], pcm_rx_data_in};
            next_rx_bit = rx_bit - 1'b1;
            if (rx_bit == pcm_codec_pkg::BIT_LAST)
            begin
               next_rx_busy = 1'b0;
               next_lin_out.valid = 1'b1;
               next_lin_out.sample = expand({rx_sh[6:0], pcm_rx_data_in},
                  companding_law_select); // RULE_01 RULE_06 RULE_07
            end
         end
      end
   end

   always_ff @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         pstate <= pcm_codec_pkg::ST_DOWN;
         frames <= pcm_codec_pkg::FRAME_ZERO;
         fst_q <= 1'b0;
         fsr_q <= 1'b0;
         tx_busy <= 1'b0;
         tx_bit <= '0;
         tx_sh <= '0;
         rx_busy <= 1'b0;
         rx_bit <= '0;
         rx_sh <= '0;
         lin_out <= '0;
      end
      else
      begin
         pstate <= next_pstate;
         frames <= next_frames;
         fst_q <= next_fst_q;
         fsr_q <= next_fsr_q;
         tx_busy <= next_tx_busy;
         tx_bit <= next_tx_bit;
         tx_sh <= next_tx_sh;
         rx_busy <= next_rx_busy;
         rx_bit <= next_rx_bit;
         rx_sh <= next_rx_sh;
         lin_out <= next_lin_out;
      end
   end

   // msb first; enable only during the shift window
   assign pcm_tx_data_out = tx_sh[pcm_codec_pkg::SIGN_POS];
   assign pcm_tx_data_oe = tx_busy && run; // RULE_12 RULE_09

   a_oe_needs_run: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE_09
      pcm_tx_data_oe |-> run) else $error("tx output driven while not running");
   a_down_floats: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE_08
      !power_down_in_n |=> !pcm_tx_data_oe) else $error("tx driven in power down");
   a_wake_floats: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE_10
      $rose(pstate == pcm_codec_pkg::ST_WAKE) |-> !pcm_tx_data_oe throughout
      (!fst_rise [*1] ##1 1'b1)) else $error("tx driven early in wake");
   a_run_after_two: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE_10
      $rose(run) |-> $past(frames) == 2'(PWRUP_FRAMES - 1)) else $error("woke too soon");
   a_shift_len: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE_12
      $rose(tx_busy) |-> tx_bit == pcm_codec_pkg::BIT_FIRST) else $error("bad shift start");
   a_expand_pulse: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE_07
      lin_out.valid |=> !lin_out.valid) else $error("expand valid too long");
   a_rx_done: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE_07
      lin_out.valid |-> !rx_busy && $past(rx_busy)) else $error("expand without receive");
   a_tx_load: assert property (@(posedge core_clk) disable iff (!arst_n) // RULE_12
      fifo_ready && fifo_valid && power_down_in_n |=>
      pcm_tx_data_oe && tx_bit == pcm_codec_pkg::BIT_FIRST) else $error("load not driven");
endmodule
`default_nettype wire

// ### verif/pcm_highway_model.sv
`timescale 1ns/1ps
`default_nettype none
module pcm_highway_model (
   // clock
   input wire logic core_clk,
   // frame and bit timing to the codec
   output logic tx_frame_sync,
   output logic rx_frame_sync,
   output logic tx_bit_tick,
   output logic rx_bit_tick,
   // serial lines
   output logic pcm_rx_data_in,
   input wire logic pcm_tx_data_out,
   input wire logic pcm_tx_data_oe
);
   initial
   begin
      tx_frame_sync = 1'b0;
      rx_frame_sync = 1'b0;
      tx_bit_tick = 1'b0;
      rx_bit_tick = 1'b0;
      pcm_rx_data_in = 1'b1;
   end

   // gap sets the idle cycles before each tick, so slow highways are covered
   task automatic tx_frame(input int gap, output logic [7:0] code, output int drv);
      drv = 0;
      @(negedge core_clk) tx_frame_sync = 1'b1;
      @(negedge core_clk) tx_frame_sync = 1'b0;
      for (int i = 7; i >= 0; i--)
      begin
         repeat (gap) @(negedge core_clk);
         code[i] = pcm_tx_data_out;
         drv += int'(pcm_tx_data_oe);
         tx_bit_tick = 1'b1;
         @(negedge core_clk) tx_bit_tick = 1'b0;
      end
   endtask

   task automatic rx_frame(input logic [7:0] code, input int gap);
      @(negedge core_clk) rx_frame_sync = 1'b1;
      @(negedge core_clk) rx_frame_sync = 1'b0;
      for (int i = 7; i >= 0; i--)
      begin
         pcm_rx_data_in = code[i];
         repeat (gap) @(negedge core_clk);
         rx_bit_tick = 1'b1;
         @(negedge core_clk) rx_bit_tick = 1'b0;
      end
      // no stale bit after the frame: show the inverse
      pcm_rx_data_in = ~code[0];
   endtask
endmodule
`default_nettype wire

// ### verif/test_pcm_companding_codec_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module test_pcm_companding_codec_ctrl;
   logic core_clk = 1'b0;
   logic arst_n = 1'b0;
   logic law = 1'b1;
   logic pwr_n = 1'b0;
   logic lin_in_valid = 1'b0;
   logic [12:0] lin_in = 13'h0000;
   logic lin_in_ready, oe, txd, rxd, fs_t, fs_r, tk_t, tk_r, powered_up, took;
   pcm_codec_pkg::lin_word_t lin_out;
   int error_cnt = 0;
   int num_checks = 0;
   int cyc = 0;
   int drv;
   logic [7:0] code;
   // law, linear sample, companded code
   logic [21:0] enc_tab [6] = '{{1'b1, 13'h0000, 8'h7f}, {1'b1, 13'h1fff, 8'hfe},
      {1'b1, 13'h001e, 8'h70}, {1'b0, 13'h0000, 8'hd5}, {1'b0, 13'h1ffe, 8'h54},
      {1'b0, 13'h0040, 8'hf5}};
   // law, code, expanded sample
   logic [21:0] dec_tab [4] = '{{1'b0, 8'hd5, 13'h0001}, {1'b0, 8'hf5, 13'h0042},
      {1'b0, 8'h54, 13'h1ffd}, {1'b1, 8'hff, 13'h0000}};

   always #12.5 core_clk = ~core_clk;

   pcm_companding_codec_ctrl #(.FIFO_DEPTH(16), .PWRUP_FRAMES(2)) dut (
      .core_clk(core_clk), .arst_n(arst_n), .companding_law_select(law),
      .power_down_in_n(pwr_n), .tx_frame_sync(fs_t), .rx_frame_sync(fs_r),
      .tx_bit_tick(tk_t), .rx_bit_tick(tk_r), .lin_in_valid(lin_in_valid),
      .lin_in_ready(lin_in_ready), .lin_in(lin_in), .pcm_tx_data_out(txd),
      .pcm_tx_data_oe(oe), .pcm_rx_data_in(rxd), .lin_out(lin_out),
      .powered_up(powered_up));

   pcm_highway_model hw (
      .core_clk(core_clk), .tx_frame_sync(fs_t), .rx_frame_sync(fs_r),
      .tx_bit_tick(tk_t), .rx_bit_tick(tk_r), .pcm_rx_data_in(rxd),
      .pcm_tx_data_out(txd), .pcm_tx_data_oe(oe));

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
      num_checks++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("[ERR] %0t %s seen %h exp %h", $time, what, seen, exp);
      end
   endtask

   task automatic test_done;
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // offer one sample; released after one edge whether taken or not
   task automatic push(input logic [12:0] s);
      @(negedge core_clk);
      lin_in = s;
      lin_in_valid = 1'b1;
      @(posedge core_clk) took = lin_in_ready;
      @(negedge core_clk) lin_in_valid = 1'b0;
   endtask

   task automatic t_powerup;
      @(negedge core_clk) pwr_n = 1'b1;
      push(13'h0000);
      chk(took, 0, "ready early");
      hw.tx_frame(1, code, drv);
      chk(16'(drv), 0, "oe frame 1");
      chk(powered_up, 0, "up early");
      hw.tx_frame(1, code, drv);
      chk(16'(drv), 0, "oe frame 2");
      repeat (2) @(negedge core_clk);
      chk(powered_up, 1, "not up");
      $display("powerup done");
   endtask

   task automatic t_encode;
      foreach (enc_tab[i])
      begin
         law = enc_tab[i][21];
         push(enc_tab[i][20:8]);
         chk(took, 1, "enc take");
         hw.tx_frame(1, code, drv);
         chk(16'(drv), 8, "enc oe");
         chk(code, enc_tab[i][7:0], "enc code");
         repeat (2) @(negedge core_clk);
         chk(oe, 0, "oe after");
      end
      $display("encode done");
   endtask

   task automatic t_decode;
      logic got;
      logic [12:0] val;
      foreach (dec_tab[i])
      begin
         law = dec_tab[i][21];
         got = 1'b0;
         val = 13'h0000;
         hw.rx_frame(dec_tab[i][20:13], 2);
         for (int k = 0; k < 20 && !got; k++)
         begin
            if (lin_out.valid === 1'b1)
            begin
               got = 1'b1;
               val = lin_out.sample;
            end
            @(negedge core_clk);
         end
         chk(got, 1, "dec valid");
         chk(val, dec_tab[i][12:0], "dec sample");
      end
      $display("decode done");
   endtask

   task automatic t_fifo;
      law = 1'b1;
      for (int i = 0; i < 16; i++)
      begin
         push(13'h0000);
         chk(took, 1, "fill");
      end
      push(13'h0000);
      chk(took, 0, "full take");
      for (int i = 0; i < 16; i++)
      begin
         hw.tx_frame(3, code, drv);
         chk(16'(drv), 8, "drain oe");
         chk(code, 8'h7f, "drain code");
      end
      hw.tx_frame(1, code, drv);
      chk(16'(drv), 0, "empty oe");
      $display("fifo done");
   endtask

   task automatic t_pwrdown;
      push(13'h0040);
      fork
         hw.tx_frame(4, code, drv);
         begin
            repeat (12) @(negedge core_clk);
            pwr_n = 1'b0;
            repeat (2) @(negedge core_clk);
            chk(oe, 0, "oe down");
            chk(powered_up, 0, "up down");
         end
      join
      push(13'h0000);
      chk(took, 0, "take down");
      hw.tx_frame(1, code, drv);
      chk(16'(drv), 0, "oe frame down");
      $display("pwrdown done");
   endtask

   // every test is a few hundred cycles; this ceiling only cuts a hang
   always @(posedge core_clk)
   begin
      cyc++;
      if (cyc == 40000)
      begin
         error_cnt++;
         test_done();
      end
   end

   initial
   begin
      repeat (10) @(posedge core_clk);
      chk(oe, 0, "oe reset");
      @(negedge core_clk) arst_n = 1'b1;
      t_powerup();
      t_encode();
      t_decode();
      t_fifo();
      t_pwrdown();
      test_done();
   end
endmodule
`default_nettype wire
